// File: core/omccs_regs.svh
// Offsets, field positions, reset values and timing counts of the clock mode block.
`ifndef OMCCS_REGS_SVH
`define OMCCS_REGS_SVH

// ============================================================================
// Register addresses
`define OMCCS_ADDR_PIN_MODE    16'hFF9F
`define OMCCS_ADDR_CPU_CTRL    16'hFFFB
`define OMCCS_ADDR_OSC_CTRL    16'hFFA2

// ============================================================================
// Field positions
`define OMCCS_BIT_MAIN_EXT     7
`define OMCCS_BIT_MAIN_OSC     6
`define OMCCS_BIT_SUB_EXT      5
`define OMCCS_BIT_SUB_OSC      4
`define OMCCS_BIT_GAIN         0
`define OMCCS_BIT_SUB_START    6
`define OMCCS_BIT_CPU_STATUS   5
`define OMCCS_BIT_CPU_SOURCE   4
`define OMCCS_BIT_OSC_STOP     7

// ============================================================================
// Reset values and largest divider code
`define OMCCS_RST_PIN_MODE     8'h00
`define OMCCS_RST_CPU_CTRL     8'h01
`define OMCCS_RST_OSC_CTRL     8'h80
`define OMCCS_DIV_MAX          3'h4

// ============================================================================
// Timing
`define OMCCS_CLK_MHZ          10
`define OMCCS_GAIN_WAIT_NS     5000
`define OMCCS_GAIN_WAIT_CYC    ((`OMCCS_GAIN_WAIT_NS * `OMCCS_CLK_MHZ + 999) / 1000)
`define OMCCS_STAB_CYC_DFLT    2048

`endif

// File: core/omccs_pkg.sv
// Types shared by the clock mode block.
package omccs_pkg;

  typedef enum logic [2:0] {
    ST_RUN  = 3'b001,
    ST_HOLD = 3'b010,
    ST_STOP = 3'b100
  } omccs_state_e;

  typedef struct packed {
    logic         sub_s1;
    logic         sub_s2;
    logic         sub_s3;
    logic         sub_tgl;
    logic         main_ext;
    logic         main_osc;
    logic         sub_ext;
    logic         sub_osc;
    logic         gain;
    logic         gain_locked;
    logic         sub_start;
    logic         src_sel;
    logic [2:0]   div;
    logic         act_src;
    logic [2:0]   act_div;
    logic         status;
    logic         osc_stop;
    logic         main_hs;
    omccs_state_e fsm;
    logic [15:0]  wait_cnt;
    logic [3:0]   div_cnt;
    logic         inst_tgl;
    logic         cpu_en;
    logic         instr_slot;
    logic         pin1_osc;
    logic         pin2_ext;
    logic         amp_run;
    logic [7:0]   rdata;
  } omccs_state_s;

endpackage

// File: core/omccs_top.sv
// Clock pin mode selection, CPU clock source and divider, and CPU clock hold logic.
`timescale 1ns/1ns
`include "omccs_regs.svh"

// Rules for this block and for the software that drives it
// [RULE1] Reset clears pin mode register to zero: pins are I/O ports, low gain.
// [RULE2] Pin mode register bits: 7 ext clock, 6 osc, 5/4 sub, 0 gain; 3..1 zero.
// [RULE3] Pair 00/10 I/O port, 01 resonator on both pins, 11 external clock pin two.
// [RULE4] Software sets gain above 10 MHz up to 20 MHz, else leaves zero.
// [RULE5] Only one change of the gain bit is accepted after each reset.
// [RULE6] Setting gain to one withholds the CPU clock for at least 5 us.
// [RULE7] Leaving STOP with gain set withholds CPU clock 5 us for non-resonator main.
// [RULE8] Leaving STOP with resonator feeding CPU counts oscillation stabilization time first.
// [RULE9] Software changes ext/osc select only while main oscillator stop reads one.
// [RULE10] Software programs gain before configuring peripherals after reset.
// [RULE11] Reset loads CPU clock control with 01H: main clock divided by two.
// [RULE12] CPU control bits: 6 sub start, 5 read-only status, 4 source, 2..0 divider.
// [RULE13] Source 0 divides main by 1,2,4,8,16; source 1 gives sub clock over two.
// [RULE14] Software writes zero to CPU control bits 3 and 7.
// [RULE15] Fastest instruction takes two CPU clock periods.
// [RULE16] Main oscillator stop bit 7 stops resonator or external input while one; the code gates only the resonator amplifier, not pin two.
// [RULE17] Main clock status reads zero for internal oscillator, one for high-speed.
// [RULE18] Source and divider switch only at clock boundaries; status follows switch.
module omccs_top #(
  parameter int unsigned STAB_CYCLES = `OMCCS_STAB_CYC_DFLT
) (
  input  wire logic        core_clk_i,
  input  wire logic        rst_n_i,
  input  wire logic [15:0] mem_addr_i,
  input  wire logic        mem_wr_i,
  input  wire logic        mem_rd_i,
  input  wire logic        mem_bit_i,
  input  wire logic [2:0]  mem_bit_idx_i,
  input  wire logic [7:0]  mem_wdata_i,
  output logic      [7:0]  mem_rdata_o,
  input  wire logic        stop_mode_i,
  input  wire logic        main_clk_is_hs_i,
  input  wire logic        sub_clk_i,
  output logic             cpu_clk_en_o,
  output logic             instr_slot_o,
  output logic             cpu_clock_status_o,
  output logic             main_clock_status_o,
  output logic             pin1_osc_en_o,
  output logic             pin2_extclk_en_o,
  output logic             osc_amp_run_o,
  output logic             gain_band_sel_o,
  output logic             sub_ext_clock_sel_o,
  output logic             sub_osc_sel_o,
  output logic             sub_osc_start_o
);

  // ============================================================================
  // Constants
  localparam logic [15:0] GAIN_WAIT = 16'(`OMCCS_GAIN_WAIT_CYC);
  localparam logic [15:0] STAB_WAIT = 16'(STAB_CYCLES);
  localparam logic [7:0]  RST_PIN   = `OMCCS_RST_PIN_MODE;
  localparam logic [7:0]  RST_CPU   = `OMCCS_RST_CPU_CTRL;
  localparam logic [7:0]  RST_OSC   = `OMCCS_RST_OSC_CTRL;

  // Every field is a literal or comes from a reset constant, so the reset branch stays constant.
  localparam omccs_pkg::omccs_state_s RST_STATE = '{
    sub_s1:      1'b0,
    sub_s2:      1'b0,
    sub_s3:      1'b0,
    sub_tgl:     1'b0,
    main_ext:    RST_PIN[`OMCCS_BIT_MAIN_EXT],
    main_osc:    RST_PIN[`OMCCS_BIT_MAIN_OSC],
    sub_ext:     RST_PIN[`OMCCS_BIT_SUB_EXT],
    sub_osc:     RST_PIN[`OMCCS_BIT_SUB_OSC],
    gain:        RST_PIN[`OMCCS_BIT_GAIN],
    gain_locked: 1'b0,
    sub_start:   RST_CPU[`OMCCS_BIT_SUB_START],
    src_sel:     RST_CPU[`OMCCS_BIT_CPU_SOURCE],
    div:         RST_CPU[2:0],
    act_src:     RST_CPU[`OMCCS_BIT_CPU_SOURCE],
    act_div:     RST_CPU[2:0],
    status:      RST_CPU[`OMCCS_BIT_CPU_STATUS],
    osc_stop:    RST_OSC[`OMCCS_BIT_OSC_STOP],
    main_hs:     1'b0,
    fsm:         omccs_pkg::ST_RUN,
    wait_cnt:    16'h0000,
    div_cnt:     4'h0,
    inst_tgl:    1'b0,
    cpu_en:      1'b0,
    instr_slot:  1'b0,
    pin1_osc:    RST_PIN[`OMCCS_BIT_MAIN_OSC] & ~RST_PIN[`OMCCS_BIT_MAIN_EXT],
    pin2_ext:    RST_PIN[`OMCCS_BIT_MAIN_OSC] & RST_PIN[`OMCCS_BIT_MAIN_EXT],
    amp_run:     1'b0,
    rdata:       8'h00
  };

  // ============================================================================
  // Functions

  // A bit instruction touches only the indexed bit; a byte write replaces all.
  function automatic logic [7:0] bit_merge(input logic [7:0] old_val,
                                           input logic [7:0] new_val,
                                           input logic       is_bit,
                                           input logic [2:0] idx);
    logic [7:0] mask;
    mask = 8'h01 << idx;
    return is_bit ? ((old_val & ~mask) | (new_val & mask)) : new_val;
  endfunction

  // Low counter bits that must all be one for a divided main clock tick.
  function automatic logic [3:0] div_mask(input logic [2:0] code);
    logic [3:0] m;
    unique case (code)
      3'h0:    m = 4'h0;
      3'h1:    m = 4'h1;
      3'h2:    m = 4'h3;
      3'h3:    m = 4'h7;
      3'h4:    m = 4'hF;
      default: m = 4'hF;
    endcase
    return m;
  endfunction

  // ============================================================================
  // State
  omccs_pkg::omccs_state_s st_r;
  omccs_pkg::omccs_state_s st_nxt;
  logic [7:0]              pin_rd;
  logic [7:0]              cpu_rd;
  logic [7:0]              osc_rd;
  logic [7:0]              pin_wv;
  logic [7:0]              cpu_wv;
  logic [7:0]              osc_wv;
  logic                    wr_pin;
  logic                    wr_cpu;
  logic                    wr_osc;
  logic                    sub_rise;
  logic                    main_tick;
  logic                    sub_tick;
  logic                    src_tick;
  logic                    gain_up;
  logic                    x1_feeds;

  // ============================================================================
  // Next state
  always_comb begin
    st_nxt    = st_r;
    pin_rd    = {st_r.main_ext, st_r.main_osc, st_r.sub_ext, st_r.sub_osc, 3'b000, st_r.gain}; // RULE2
    cpu_rd    = {1'b0, st_r.sub_start, st_r.status, st_r.src_sel, 1'b0, st_r.div}; // RULE12
    osc_rd    = {st_r.osc_stop, 7'h00}; // RULE16
    wr_pin    = mem_wr_i && (mem_addr_i == `OMCCS_ADDR_PIN_MODE);
    wr_cpu    = mem_wr_i && (mem_addr_i == `OMCCS_ADDR_CPU_CTRL);
    wr_osc    = mem_wr_i && (mem_addr_i == `OMCCS_ADDR_OSC_CTRL);
    pin_wv    = bit_merge(pin_rd, mem_wdata_i, mem_bit_i, mem_bit_idx_i);
    cpu_wv    = bit_merge(cpu_rd, mem_wdata_i, mem_bit_i, mem_bit_idx_i);
    osc_wv    = bit_merge(osc_rd, mem_wdata_i, mem_bit_i, mem_bit_idx_i);
    gain_up   = 1'b0;

    // The subsystem clock is foreign: two flops first, the third only for the edge.
    st_nxt.sub_s1 = sub_clk_i;
    st_nxt.sub_s2 = st_r.sub_s1;
    st_nxt.sub_s3 = st_r.sub_s2;
    sub_rise      = st_r.sub_s2 & ~st_r.sub_s3;
    sub_tick      = sub_rise & st_r.sub_tgl; // RULE13
    if (sub_rise) begin
      st_nxt.sub_tgl = ~st_r.sub_tgl;
    end
    main_tick      = (st_r.div_cnt & div_mask(st_r.act_div)) == div_mask(st_r.act_div); // RULE13
    st_nxt.div_cnt = st_r.div_cnt + 4'h1;
    src_tick       = st_r.act_src ? sub_tick : main_tick;
    x1_feeds       = st_r.main_hs & st_r.pin1_osc & ~st_r.act_src;

    // Register writes.
    if (wr_pin) begin
      st_nxt.main_ext = pin_wv[`OMCCS_BIT_MAIN_EXT];
      st_nxt.main_osc = pin_wv[`OMCCS_BIT_MAIN_OSC];
      st_nxt.sub_ext  = pin_wv[`OMCCS_BIT_SUB_EXT];
      st_nxt.sub_osc  = pin_wv[`OMCCS_BIT_SUB_OSC];
      // The gain band may change once per reset; later changes are dropped.
      if ((pin_wv[`OMCCS_BIT_GAIN] != st_r.gain) && !st_r.gain_locked) begin // RULE5
        st_nxt.gain        = pin_wv[`OMCCS_BIT_GAIN];
        st_nxt.gain_locked = 1'b1;
        gain_up            = pin_wv[`OMCCS_BIT_GAIN];
      end
    end
    if (wr_cpu) begin
      st_nxt.sub_start = cpu_wv[`OMCCS_BIT_SUB_START];
      st_nxt.src_sel   = cpu_wv[`OMCCS_BIT_CPU_SOURCE];
      // Prohibited divider codes keep the old divider rather than stall the core.
      if (cpu_wv[2:0] <= `OMCCS_DIV_MAX) begin // RULE13
        st_nxt.div = cpu_wv[2:0];
      end
    end
    if (wr_osc) begin
      st_nxt.osc_stop = osc_wv[`OMCCS_BIT_OSC_STOP]; // RULE16
    end

    // A new source or divider takes effect only on a tick of the old one.
    if (src_tick) begin // RULE18
      st_nxt.act_src = st_r.src_sel;
      st_nxt.act_div = st_r.div;
      if ((st_r.src_sel != st_r.act_src) || (st_r.div != st_r.act_div)) begin
        st_nxt.div_cnt = 4'h0;
      end
    end
    st_nxt.status = st_r.act_src; // RULE18

    // CPU clock hold sequencing.
    unique case (st_r.fsm)
      omccs_pkg::ST_RUN: begin
        if (stop_mode_i) begin
          st_nxt.fsm = omccs_pkg::ST_STOP;
        end else if (gain_up) begin // RULE6
          st_nxt.fsm      = omccs_pkg::ST_HOLD;
          st_nxt.wait_cnt = GAIN_WAIT;
        end
      end
      omccs_pkg::ST_HOLD: begin
        if (st_r.wait_cnt <= 16'h0001) begin
          st_nxt.fsm = stop_mode_i ? omccs_pkg::ST_STOP : omccs_pkg::ST_RUN;
        end else begin
          st_nxt.wait_cnt = st_r.wait_cnt - 16'h0001;
        end
      end
      omccs_pkg::ST_STOP: begin
        if (!stop_mode_i) begin
          if (x1_feeds) begin // RULE8
            st_nxt.fsm      = omccs_pkg::ST_HOLD;
            st_nxt.wait_cnt = STAB_WAIT;
          end else if (st_r.gain) begin // RULE7
            st_nxt.fsm      = omccs_pkg::ST_HOLD;
            st_nxt.wait_cnt = GAIN_WAIT;
          end else begin
            st_nxt.fsm = omccs_pkg::ST_RUN;
          end
        end
      end
    endcase

    st_nxt.cpu_en = (st_nxt.fsm == omccs_pkg::ST_RUN) && src_tick;
    if (st_nxt.cpu_en) begin
      st_nxt.inst_tgl = ~st_r.inst_tgl;
    end
    st_nxt.instr_slot = st_nxt.cpu_en & st_r.inst_tgl; // RULE15

    // Pin modes follow the written value in the same edge.
    st_nxt.pin1_osc = st_nxt.main_osc & ~st_nxt.main_ext; // RULE3
    st_nxt.pin2_ext = st_nxt.main_osc & st_nxt.main_ext; // RULE3
    st_nxt.amp_run  = st_nxt.pin1_osc & ~st_nxt.osc_stop & (st_nxt.fsm != omccs_pkg::ST_STOP); // RULE16
    st_nxt.main_hs  = main_clk_is_hs_i; // RULE17

    if (mem_rd_i) begin
      if (mem_addr_i == `OMCCS_ADDR_PIN_MODE) begin
        st_nxt.rdata = pin_rd;
      end else if (mem_addr_i == `OMCCS_ADDR_CPU_CTRL) begin
        st_nxt.rdata = cpu_rd;
      end else if (mem_addr_i == `OMCCS_ADDR_OSC_CTRL) begin
        st_nxt.rdata = osc_rd;
      end else begin
        st_nxt.rdata = 8'h00;
      end
    end
  end

  // ============================================================================
  // Registers
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_r <= RST_STATE; // RULE1 RULE11
    end else begin
      st_r <= st_nxt;
    end
  end

  // ============================================================================
  // Outputs
  assign mem_rdata_o         = st_r.rdata;
  assign cpu_clk_en_o        = st_r.cpu_en;
  assign instr_slot_o        = st_r.instr_slot;
  assign cpu_clock_status_o  = st_r.status;
  assign main_clock_status_o = st_r.main_hs;
  assign pin1_osc_en_o       = st_r.pin1_osc;
  assign pin2_extclk_en_o    = st_r.pin2_ext;
  assign osc_amp_run_o       = st_r.amp_run;
  assign gain_band_sel_o     = st_r.gain;
  assign sub_ext_clock_sel_o = st_r.sub_ext;
  assign sub_osc_sel_o       = st_r.sub_osc;
  assign sub_osc_start_o     = st_r.sub_start;

endmodule // omccs_top

// File: dv/omccs_props.sv
// Port checker for the clock mode block.
`timescale 1ns/1ns
module omccs_props (
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic cpu_clk_en_o,
  input wire logic pin1_osc_en_o,
  input wire logic pin2_extclk_en_o,
  input wire logic gain_band_sel_o,
  input wire logic stop_mode_i,
  input wire logic main_clk_is_hs_i,
  input wire logic main_clock_status_o,
  input wire logic instr_slot_o,
  input wire logic osc_amp_run_o
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);
  a_pin_mode_excl: assert property (!(pin1_osc_en_o && pin2_extclk_en_o))
    else $error("two pin modes");
  a_gain_no_fall: assert property (!$fell(gain_band_sel_o))
    else $error("gain changed twice");
  a_gain_cpu_hold: assert property ($rose(gain_band_sel_o) |-> ##[0:2] !cpu_clk_en_o [*8])
    else $error("cpu clock not held");
  a_stop_cpu_off: assert property (stop_mode_i |=> !cpu_clk_en_o)
    else $error("cpu clock during stop");
  a_slot_on_tick: assert property (instr_slot_o |-> cpu_clk_en_o)
    else $error("slot without cpu tick");
  a_amp_needs_pin: assert property (osc_amp_run_o |-> pin1_osc_en_o)
    else $error("amplifier without resonator mode");
  a_main_status: assert property (main_clock_status_o == $past(main_clk_is_hs_i))
    else $error("main clock status wrong");
  c_gain: cover property ($rose(gain_band_sel_o));
  c_osc: cover property (pin1_osc_en_o);
  c_ext: cover property (pin2_extclk_en_o);
endmodule // omccs_props
bind omccs_top omccs_props u_props (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .cpu_clk_en_o(cpu_clk_en_o),
  .pin1_osc_en_o(pin1_osc_en_o), .pin2_extclk_en_o(pin2_extclk_en_o), .gain_band_sel_o(gain_band_sel_o),
  .stop_mode_i(stop_mode_i), .main_clk_is_hs_i(main_clk_is_hs_i), .main_clock_status_o(main_clock_status_o),
  .instr_slot_o(instr_slot_o), .osc_amp_run_o(osc_amp_run_o));

// File: dv/omccs_partner.sv
// Subsystem clock source model.
`timescale 1ns/1ns
module omccs_partner (
  input  wire logic core_clk_i,
  output logic      sub_clk_o
);
  logic [2:0] cnt_r = 3'h0;
  // A short period keeps the run brief; a real watch crystal is far slower.
  always_ff @(posedge core_clk_i) cnt_r <= cnt_r + 3'h1;
  assign sub_clk_o = cnt_r[2];
endmodule // omccs_partner

// File: dv/omccs_top_bench.sv
// Random and directed test of the clock mode block.
`timescale 1ns/1ns
module omccs_top_bench;
  localparam int SUB_PERIOD = 8;
  logic        c = 0, r = 0, w = 0, rd = 0, sc, x1, x2, ce, slot, cpu_clock_status, main_clock_status, amp, g, stp = 0, hs = 0;
  logic [15:0] a = 16'h0000;
  logic [7:0]  wd = 8'h00, q, d, v;
  int          miscompares = 0, checks_done = 0, cyc = 0, n_ce = 0, n_slot = 0;
  omccs_top #(.STAB_CYCLES(16)) u_dut (.core_clk_i(c), .rst_n_i(r), .mem_addr_i(a), .mem_wr_i(w), .mem_rd_i(rd),
    .mem_bit_i(1'b0), .mem_bit_idx_i(3'h0), .mem_wdata_i(wd), .mem_rdata_o(q), .stop_mode_i(stp),
    .main_clk_is_hs_i(hs), .sub_clk_i(sc), .cpu_clk_en_o(ce), .instr_slot_o(slot), .cpu_clock_status_o(cpu_clock_status),
    .main_clock_status_o(main_clock_status), .pin1_osc_en_o(x1), .pin2_extclk_en_o(x2), .osc_amp_run_o(amp),
    .gain_band_sel_o(g), .sub_ext_clock_sel_o(), .sub_osc_sel_o(), .sub_osc_start_o());
  omccs_partner u_sub (.core_clk_i(c), .sub_clk_o(sc));
  initial forever #50 c = ~c;
  always @(posedge c) if (++cyc > 3000) begin miscompares++; test_done(); end
  task automatic acc(input logic [15:0] ad, input logic wr, input logic [7:0] val);
    @(negedge c); a = ad; w = wr; rd = !wr; wd = val;
    @(negedge c); d = q; w = 0; rd = 0;
  endtask
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin miscompares++; $display("[FAIL] %0t got %h want %h", $time, seen, exp); end
  endtask
  task automatic test_done();
    if (miscompares == 0 && checks_done > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  function automatic logic [7:0] pins(input logic [7:0] m);
    return {6'h00, m[7] & m[6], !m[7] & m[6]};
  endfunction
  // CPU ticks in a window: main clock over 2^code, or subsystem clock over two.
  function automatic logic [7:0] ticks(input logic src, input logic [2:0] code, input int win);
    return src ? 8'(win / (2 * SUB_PERIOD)) : 8'(win >> code);
  endfunction
  task automatic count(input int nc);
    n_ce = 0;
    n_slot = 0;
    repeat (nc) begin
      @(negedge c);
      n_ce += int'(ce);
      n_slot += int'(slot);
    end
  endtask
  initial begin
    void'($urandom(20358));
    repeat (6) @(negedge c);
    r = 1;
    acc(16'hFF9F, 0, 8'h00); chk(d, 8'h00);
    acc(16'hFFFB, 0, 8'h00); chk(d, 8'h01);
    acc(16'hFFA2, 0, 8'h00); chk(d, 8'h80);
    count(32); chk(8'(n_ce), ticks(1'b0, 3'h1, 32));
    chk(8'(n_slot), 8'h08);
    for (int i = 0; i < 4; i++) begin
      v = {i[1:0], 6'($urandom) & 6'h3E};
      acc(16'hFF9F, 1, v); acc(16'hFF9F, 0, 8'h00); chk(d, v & 8'hF1);
      chk({6'h00, x2, x1}, pins(v));
    end
    acc(16'hFF9F, 1, 8'h40);
    acc(16'hFFA2, 1, 8'h00); chk({7'h00, amp}, 8'h01);
    acc(16'hFF9F, 1, 8'h41);
    count(45); chk(8'(n_ce), 8'h00);
    count(20); chk({7'h00, n_ce > 0}, 8'h01);
    acc(16'hFF9F, 1, 8'h40); acc(16'hFF9F, 0, 8'h00); chk(d, 8'h41);
    chk({7'h00, g}, 8'h01);
    acc(16'hFFFB, 1, 8'h03); count(16);
    count(64); chk(8'(n_ce), ticks(1'b0, 3'h3, 64));
    chk(8'(n_slot), 8'h04);
    acc(16'hFFFB, 0, 8'h00); chk(d, 8'h03);
    acc(16'hFFFB, 1, 8'h10); count(40); chk({7'h00, cpu_clock_status}, 8'h01);
    acc(16'hFFFB, 0, 8'h00); chk(d, 8'h30);
    count(64); chk(8'(n_ce), ticks(1'b1, 3'h0, 64));
    acc(16'hFFFB, 1, 8'h01); count(40); chk({7'h00, cpu_clock_status}, 8'h00);
    hs = 1; @(negedge c); chk({7'h00, main_clock_status}, 8'h01);
    stp = 1; count(4); chk(8'(n_ce), 8'h00);
    chk({7'h00, amp}, 8'h00);
    stp = 0; count(14); chk(8'(n_ce), 8'h00);
    count(10); chk({7'h00, n_ce > 0}, 8'h01);
    hs = 0; @(negedge c); stp = 1; count(4);
    stp = 0; count(45); chk(8'(n_ce), 8'h00);
    count(15); chk({7'h00, n_ce > 0}, 8'h01);
    test_done();
  end
endmodule // omccs_top_bench
